// >>> design/smsm_serial_unit.sv
`timescale 1ns/1ps
`default_nettype none
module smsm_serial_unit import smsm_pkg::*; (
    input wire logic i_sys_clk, // system clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_mode_sync, // 1 clocked synchronous, 0 async
    input wire logic i_mp_format, // multiprocessor frame format
    input wire logic i_parity_enable, // even parity in plain async
    input wire logic i_msb_first, // synchronous bit order
    input wire logic i_clock_select_low, // clock select bit 0
    input wire logic i_clock_select_high, // clock select bit 1, external
    input wire logic i_transmit_enable, // transmit enable
    input wire logic i_receive_enable, // receive enable
    input wire logic i_transmit_empty_irq_enable, // empty irq enable
    input wire logic i_transmit_end_irq_enable, // end irq enable
    input wire logic i_receive_irq_enable, // receive irq enable
    input wire logic i_transmit_marker_bit, // marker sent with next frame
    input wire logic i_set_address_wait, // pulse, sets address wait
    input wire logic [7:0] i_baud_div, // tick period minus one
    input wire logic [7:0] i_tx_data, // transmit word
    input wire logic i_tx_valid, // transmit word valid
    output logic o_tx_ready, // buffer has room
    input wire logic i_clear_receive_full, // pulse clears receive full
    input wire logic i_clear_overrun, // pulse clears overrun
    input wire logic i_clear_framing, // pulse clears framing error
    input wire logic i_clear_parity, // pulse clears parity error
    output logic [7:0] o_receive_buffer, // received character
    output logic o_receive_full_flag, // receive full
    output logic o_overrun_flag, // overrun
    output logic o_framing_error_flag, // framing error
    output logic o_parity_error_flag, // parity error
    output logic o_transmit_empty_flag, // transmit empty
    output logic o_transmit_end_flag, // transmit end
    output logic o_received_marker_bit, // last marker received
    output logic o_address_wait_enable, // waiting for id frame
    output logic o_transmit_empty_interrupt, // level irq
    output logic o_transmit_end_interrupt, // level irq
    output logic o_receive_full_interrupt, // level irq
    output logic o_receive_error_interrupt, // level irq
    input wire logic i_rxd, // receive data pin
    output logic o_txd, // transmit data pin
    input wire logic i_sck, // serial clock pin in
    output logic o_sck, // serial clock pin out
    output logic o_sck_oe // serial clock drive enable
);
    smsm_state_t st, n;
    logic tick, tk, ext, extra, err, push, pop, rise, fall, done, d_fe, d_pe, d_ex;
    logic [3:0] stop_bit;

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        n = st;
        tk = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        done = 1'b0;
        d_fe = 1'b0;
        d_pe = 1'b0;
        d_ex = 1'b0;
        n.rxd_m = i_rxd;
        n.rxd_s = st.rxd_m;
        n.rxd_d = st.rxd_s;
        n.sck_m = i_sck;
        n.sck_s = st.sck_m;
        n.sck_d = st.sck_s;
        tick = st.div_cnt == i_baud_div;
        n.div_cnt = tick ? 8'h00 : st.div_cnt + 8'h01;
        ext = i_clock_select_high;
        extra = i_mp_format | i_parity_enable;
        stop_bit = extra ? SMSM_STOP_EXTRA : SMSM_STOP_PLAIN;
        err = st.overrun_flag | st.framing_error_flag | st.parity_error_flag;
        // two-entry buffer in front of the transmit buffer
        push = i_tx_valid & st.tx_ready;
        pop = (st.f_cnt != 2'h0) & st.transmit_empty_flag & i_transmit_enable;
        if (push) begin
            n.fifo[st.f_head ^ st.f_cnt[0]] = i_tx_data;
        end
        if (pop) begin
            n.transmit_buffer = st.fifo[st.f_head];
            n.transmit_empty_flag = 1'b0;
            n.transmit_end_flag = 1'b0;
            n.f_head = ~st.f_head;
        end
        n.f_cnt = st.f_cnt + {1'b0, push} - {1'b0, pop};
        // software clears first so a same-cycle hardware set wins
        if (i_clear_receive_full) n.receive_full_flag = 1'b0;
        if (i_clear_overrun) n.overrun_flag = 1'b0;
        if (i_clear_framing) n.framing_error_flag = 1'b0;
        if (i_clear_parity) n.parity_error_flag = 1'b0;
        if (i_set_address_wait) n.address_wait_enable = 1'b1;
        if (i_mode_sync) begin
            rise = ext ? (st.sck_s & ~st.sck_d) : (st.act & tick & ~st.sck_out);
            fall = ext ? (~st.sck_s & st.sck_d) : (st.act & tick & st.sck_out);
            if (!ext && st.act && tick) begin
                n.sck_out = ~st.sck_out;
            end
            if (!st.act) begin
                n.sck_out = 1'b1;
                if (!err && ((i_transmit_enable && !st.transmit_empty_flag)
                        || (i_receive_enable && !i_transmit_enable))) begin
                    n.act = 1'b1;
                    n.s_bit = 3'h0;
                    n.tx_more = 1'b0;
                    n.tx_busy = i_transmit_enable;
                    if (i_transmit_enable) begin
                        n.transmit_shift_register = st.transmit_buffer;
                        n.transmit_empty_flag = 1'b1;
                    end
                end
            end else begin
                if (fall && st.tx_busy) begin
                    n.txd = st.transmit_shift_register[st.s_bit ^ {3{i_msb_first}}];
                end
                if (fall && st.s_bit == SMSM_SYNC_LAST) begin
                    n.tx_more = st.tx_busy & i_transmit_enable & ~st.transmit_empty_flag & ~err;
                end
                if (rise) begin
                    if (i_receive_enable) begin
                        n.receive_shift_register[st.s_bit ^ {3{i_msb_first}}] = st.rxd_s;
                    end
                    n.s_bit = st.s_bit + 3'h1;
                    if (st.s_bit == SMSM_SYNC_LAST) begin
                        done = i_receive_enable;
                        if (st.tx_more) begin
                            n.transmit_shift_register = st.transmit_buffer;
                            n.transmit_empty_flag = 1'b1;
                            n.tx_more = 1'b0;
                        end else begin
                            n.act = 1'b0;
                            n.transmit_end_flag = st.tx_busy | st.transmit_end_flag;
                            n.tx_busy = 1'b0;
                        end
                    end
                end
            end
        end else begin
            tk = ext ? (st.sck_s & ~st.sck_d) : tick;
            n.act = 1'b0;
            n.sck_out = ~st.tx_sub[3];
            if (!st.tx_busy) begin
                if (i_transmit_enable && !st.transmit_empty_flag && !err) begin
                    n.transmit_shift_register = st.transmit_buffer;
                    n.transmit_empty_flag = 1'b1;
                    n.tx_mark = i_mp_format ? i_transmit_marker_bit : ^st.transmit_buffer;
                    n.tx_busy = 1'b1;
                    n.tx_bit = SMSM_START_BIT;
                    n.tx_sub = 4'h0;
                end
            end else if (tk) begin
                n.tx_sub = st.tx_sub + 4'h1;
                if (st.tx_sub == SMSM_TICK_LAST) begin
                    n.tx_bit = st.tx_bit + 4'h1;
                    if (st.tx_bit == stop_bit) begin
                        n.tx_busy = st.tx_more;
                        n.tx_more = 1'b0;
                        n.tx_bit = SMSM_START_BIT;
                    end else if (st.tx_bit + 4'h1 == stop_bit) begin
                        if (!st.transmit_empty_flag && i_transmit_enable && !err) begin
                            n.transmit_shift_register = st.transmit_buffer;
                            n.transmit_empty_flag = 1'b1;
                            n.tx_mark = i_mp_format ? i_transmit_marker_bit : ^st.transmit_buffer;
                            n.tx_more = 1'b1;
                        end else begin
                            n.transmit_end_flag = 1'b1;
                        end
                    end
                end
            end
            // start, data lsb first, marker or parity, stop
            if (!n.tx_busy) begin
                n.txd = 1'b1;
            end else if (n.tx_bit == SMSM_START_BIT) begin
                n.txd = 1'b0;
            end else if (n.tx_bit <= SMSM_LAST_DATA) begin
                n.txd = n.transmit_shift_register[3'(n.tx_bit - 4'h1)];
            end else begin
                n.txd = (n.tx_bit == SMSM_EXTRA_BIT && extra) ? n.tx_mark : 1'b1;
            end
            if (!st.rx_busy) begin
                if (i_receive_enable && !err && st.rxd_d && !st.rxd_s) begin
                    n.rx_busy = 1'b1;
                    n.rx_bit = SMSM_START_BIT;
                    n.rx_sub = 4'h0;
                end
            end else if (tk) begin
                n.rx_sub = st.rx_sub + 4'h1;
                if (st.rx_sub == SMSM_TICK_MID) begin
                    if (st.rx_bit == SMSM_START_BIT) begin
                        n.rx_busy = ~st.rxd_s;
                    end else if (st.rx_bit <= SMSM_LAST_DATA) begin
                        n.receive_shift_register[3'(st.rx_bit - 4'h1)] = st.rxd_s;
                    end else if (st.rx_bit == stop_bit) begin
                        done = 1'b1;
                        n.rx_busy = 1'b0;
                        d_fe = ~st.rxd_s;
                        d_ex = extra & st.rx_extra;
                        d_pe = i_parity_enable & ~i_mp_format & (^{st.receive_shift_register, st.rx_extra});
                    end else begin
                        n.rx_extra = st.rxd_s;
                    end
                end
                if (st.rx_sub == SMSM_TICK_LAST) begin
                    n.rx_bit = st.rx_bit + 4'h1;
                end
            end
            if (!i_transmit_enable) n.tx_busy = 1'b0;
            if (!i_receive_enable) n.rx_busy = 1'b0;
        end
        // character complete
        if (done) begin
            if (n.address_wait_enable && !i_mode_sync && !(i_mp_format && d_ex)) begin
                n.receive_full_flag = n.receive_full_flag;
            end else begin
                if (n.address_wait_enable && !i_mode_sync) begin
                    n.address_wait_enable = 1'b0;
                end
                if (!i_mode_sync && i_mp_format) n.received_marker_bit = d_ex;
                n.framing_error_flag = n.framing_error_flag | d_fe;
                n.parity_error_flag = n.parity_error_flag | d_pe;
                if (n.receive_full_flag) begin
                    n.overrun_flag = 1'b1;
                end else begin
                    n.receive_buffer = n.receive_shift_register;
                    n.receive_full_flag = ~(d_fe | d_pe);
                end
            end
        end
        if (!i_transmit_enable) begin
            n.transmit_empty_flag = 1'b1;
            n.tx_busy = 1'b0;
            n.tx_more = 1'b0;
        end
        if (!i_transmit_enable && !i_receive_enable) begin
            n.act = 1'b0;
            n.sck_out = 1'b1;
        end
        n.sck_oe = ~ext & (i_mode_sync | i_clock_select_low);
        n.tx_ready = n.f_cnt != SMSM_FIFO_FULL;
        n.transmit_empty_interrupt = i_transmit_empty_irq_enable & n.transmit_empty_flag;
        n.transmit_end_interrupt = i_transmit_end_irq_enable & n.transmit_end_flag;
        n.receive_full_interrupt = i_receive_irq_enable & n.receive_full_flag;
        n.receive_error_interrupt = i_receive_irq_enable & (n.overrun_flag | n.framing_error_flag | n.parity_error_flag);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            st <= SMSM_STATE_RST;
        end else begin
            st <= n;
        end
    end

    assign o_tx_ready = st.tx_ready;
    assign o_receive_buffer = st.receive_buffer;
    assign o_receive_full_flag = st.receive_full_flag;
    assign o_overrun_flag = st.overrun_flag;
    assign o_framing_error_flag = st.framing_error_flag;
    assign o_parity_error_flag = st.parity_error_flag;
    assign o_transmit_empty_flag = st.transmit_empty_flag;
    assign o_transmit_end_flag = st.transmit_end_flag;
    assign o_received_marker_bit = st.received_marker_bit;
    assign o_address_wait_enable = st.address_wait_enable;
    assign o_transmit_empty_interrupt = st.transmit_empty_interrupt;
    assign o_transmit_end_interrupt = st.transmit_end_interrupt;
    assign o_receive_full_interrupt = st.receive_full_interrupt;
    assign o_receive_error_interrupt = st.receive_error_interrupt;
    assign o_txd = st.txd;
    assign o_sck = st.sck_out;
    assign o_sck_oe = st.sck_oe;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_id_frame;
        $past(st.address_wait_enable) ##0 $rose(st.receive_full_flag);
    endsequence

    sequence s_wait_held;
        st.address_wait_enable ##1 st.address_wait_enable;
    endsequence

    chk_marker_wake: assert property (s_id_frame |-> !st.address_wait_enable && st.received_marker_bit)
        else $error("id frame did not end the address wait");
    chk_wait_no_flags: assert property (s_wait_held |->
        !$rose(st.receive_full_flag) && !$rose(st.framing_error_flag) && !$rose(st.overrun_flag))
        else $error("flag set while waiting for an id frame");
    chk_te_off_empty: assert property (!i_transmit_enable |=> st.transmit_empty_flag)
        else $error("transmit empty not set with transmit disabled");
    chk_err_hold_tx: assert property ((st.overrun_flag || st.framing_error_flag || st.parity_error_flag)
        && !st.tx_busy && !st.act |=> !st.tx_busy)
        else $error("transmission started with an error flag set");
    chk_load_sets_empty: assert property (i_transmit_enable && !st.transmit_empty_flag
        && !(st.overrun_flag || st.framing_error_flag || st.parity_error_flag) && !st.tx_busy && !st.act
        |=> st.transmit_empty_flag && st.tx_busy)
        else $error("transmit buffer not taken into the shifter");
    chk_overrun_keep: assert property ($rose(st.overrun_flag) |-> st.receive_full_flag && $stable(st.receive_buffer))
        else $error("overrun changed receive buffer or full flag");
    chk_sck_idle_high: assert property (i_mode_sync && !st.act |=> st.sck_out || st.act)
        else $error("serial clock not high while idle");
    chk_transmit_end_flag_irq: assert property ($rose(st.transmit_end_flag) && $past(i_transmit_end_irq_enable)
        |-> st.transmit_end_interrupt)
        else $error("transmit end interrupt missing");
    chk_rx_irq: assert property ($rose(st.receive_full_flag) && $past(i_receive_irq_enable) |-> st.receive_full_interrupt)
        else $error("receive interrupt missing");
endmodule : smsm_serial_unit
`default_nettype wire

// >>> design/smsm_pkg.sv
package smsm_pkg;
    localparam logic [3:0] SMSM_TICK_LAST = 4'hF;
    localparam logic [3:0] SMSM_TICK_MID = 4'h7;
    localparam logic [3:0] SMSM_START_BIT = 4'h0;
    localparam logic [3:0] SMSM_LAST_DATA = 4'h8;
    localparam logic [3:0] SMSM_EXTRA_BIT = 4'h9;
    localparam logic [3:0] SMSM_STOP_PLAIN = 4'h9;
    localparam logic [3:0] SMSM_STOP_EXTRA = 4'hA;
    localparam logic [2:0] SMSM_SYNC_LAST = 3'h7;
    localparam logic [1:0] SMSM_FIFO_FULL = 2'h2;

    typedef struct packed {
        logic rxd_m, rxd_s, rxd_d, sck_m, sck_s, sck_d;
        logic [7:0] div_cnt;
        logic [1:0][7:0] fifo;
        logic [1:0] f_cnt;
        logic f_head, tx_ready;
        logic [7:0] transmit_buffer;
        logic transmit_empty_flag, transmit_end_flag, tx_mark, tx_busy, tx_more, txd;
        logic [3:0] tx_bit, tx_sub;
        logic [7:0] transmit_shift_register;
        logic act, sck_out, sck_oe;
        logic [2:0] s_bit;
        logic rx_busy, rx_extra;
        logic [3:0] rx_bit, rx_sub;
        logic [7:0] receive_shift_register, receive_buffer;
        logic receive_full_flag, overrun_flag, framing_error_flag, parity_error_flag, received_marker_bit, address_wait_enable;
        logic transmit_empty_interrupt, transmit_end_interrupt, receive_full_interrupt, receive_error_interrupt;
    } smsm_state_t;

    localparam smsm_state_t SMSM_STATE_RST = '{rxd_m: 1'b1, rxd_s: 1'b1, rxd_d: 1'b1,
        sck_m: 1'b1, sck_s: 1'b1, sck_d: 1'b1, tx_ready: 1'b1, transmit_empty_flag: 1'b1, transmit_end_flag: 1'b1,
        txd: 1'b1, sck_out: 1'b1, default: '0};
endpackage : smsm_pkg

// >>> tb/smsm_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial peer on the line side
// ----------------------------------------
module smsm_peer #(
    parameter int BIT_NS = 320, // 16 ticks of two clocks each
    parameter int HALF_NS = 40 // half of the 80 ns link clock
) (
    output logic o_rxd, // data into the unit
    output logic o_sck, // external serial clock
    input wire logic i_txd // data out of the unit
);
    initial begin
        o_rxd = 1'b1;
        o_sck = 1'b1;
    end

    // async frame, lsb first; a zero stop bit forces a framing fault
    task automatic send_async(input logic [7:0] d, input logic mk, input logic stp);
        logic [10:0] fr;
        fr = {stp, mk, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_rxd = fr[i];
            #(BIT_NS);
        end
        o_rxd = 1'b1;
    endtask : send_async

    // bounded wait for a start bit, then one sample in the middle of each bit;
    // a missed start leaves all ones, which can never match a real frame
    task automatic get_async(output logic [10:0] fr);
        int n;
        fr = '1;
        for (n = 0; n < 2000 && i_txd !== 1'b0; n++) #10;
        if (n < 2000) begin
            #(BIT_NS / 2);
            for (int i = 0; i < 11; i++) begin
                fr[i] = i_txd;
                #(BIT_NS);
            end
        end
    endtask : get_async

    // clock stands high outside frames; the unit's data is taken late in the
    // high phase because its pin only moves after it has synchronised our fall
    task automatic sync_frame(input logic [7:0] d, output logic [7:0] got);
        for (int i = 0; i < 8; i++) begin
            o_sck = 1'b0;
            o_rxd = d[i];
            #(HALF_NS);
            o_sck = 1'b1;
            #(HALF_NS - 10);
            got[i] = i_txd;
            #10;
        end
        o_rxd = ~d[7];
    endtask : sync_frame
endmodule : smsm_peer
`default_nettype wire

// >>> tb/test_smsm_serial_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_smsm_serial_unit;
    logic clk, rst, sync, mp, par, selh, te, re, transmit_empty_irq_enable, transmit_end_irq_enable, receive_irq_enable, setw, txv;
    logic cf, co, cfe, cpe, mkt, msbf;
    logic [7:0] div, txdat, got;
    wire logic [7:0] receive_buffer;
    wire logic rdy, full, ovr, framing_error_flag, parity_error_flag, empty, transmit_end_flag, received_marker_bit, wt, transmit_empty_interrupt, transmit_end_interrupt, receive_full_interrupt, receive_error_interrupt;
    wire logic rxd, txd, sck_in, sck_o, sck_oe;
    int num_errors = 0;
    int check_count = 0;
    int falls = 0;

    smsm_serial_unit DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_mode_sync(sync),
        .i_mp_format(mp), .i_parity_enable(par), .i_msb_first(msbf),
        .i_clock_select_low(1'b0), .i_clock_select_high(selh), .i_transmit_enable(te),
        .i_receive_enable(re), .i_transmit_empty_irq_enable(transmit_empty_irq_enable),
        .i_transmit_end_irq_enable(transmit_end_irq_enable), .i_receive_irq_enable(receive_irq_enable),
        .i_transmit_marker_bit(mkt), .i_set_address_wait(setw), .i_baud_div(div),
        .i_tx_data(txdat), .i_tx_valid(txv), .o_tx_ready(rdy), .i_clear_receive_full(cf),
        .i_clear_overrun(co), .i_clear_framing(cfe), .i_clear_parity(cpe),
        .o_receive_buffer(receive_buffer), .o_receive_full_flag(full), .o_overrun_flag(ovr),
        .o_framing_error_flag(framing_error_flag), .o_parity_error_flag(parity_error_flag),
        .o_transmit_empty_flag(empty), .o_transmit_end_flag(transmit_end_flag),
        .o_received_marker_bit(received_marker_bit), .o_address_wait_enable(wt),
        .o_transmit_empty_interrupt(transmit_empty_interrupt), .o_transmit_end_interrupt(transmit_end_interrupt),
        .o_receive_full_interrupt(receive_full_interrupt), .o_receive_error_interrupt(receive_error_interrupt), .i_rxd(rxd),
        .o_txd(txd), .i_sck(sck_in), .o_sck(sck_o), .o_sck_oe(sck_oe));
    smsm_peer peer (.o_rxd(rxd), .o_sck(sck_in), .i_txd(txd));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(negedge sck_o) falls++;

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : pulse

    task automatic put_word(input logic [7:0] d);
        int n;
        @(negedge clk);
        for (n = 0; n < 500 && rdy !== 1'b1; n++) @(negedge clk);
        if (n == 500) begin
            check(16'h0, 16'h1);
            give_verdict;
        end else begin
            txdat = d;
            txv = 1'b1;
            @(negedge clk) txv = 1'b0;
        end
    endtask : put_word

    task automatic wait_end;
        int n;
        for (n = 0; n < 500 && transmit_end_flag !== 1'b1; n++) @(negedge clk);
        if (n == 500) begin
            check(16'h0, 16'h1);
            give_verdict;
        end
    endtask : wait_end

    task automatic clear_all;
        fork
            pulse(cf);
            pulse(co);
            pulse(cfe);
            pulse(cpe);
        join
    endtask : clear_all

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        check({rdy, empty, transmit_end_flag, txd, sck_o, full, ovr, sck_oe}, 8'b11111000);
        $display("reset test done");
    endtask : test_reset

    task automatic test_mp;
        mp = 1'b1;
        par = 1'b1;
        receive_irq_enable = 1'b1;
        cyc(1);
        re = 1'b1;
        pulse(setw);
        cyc(2);
        check(wt, 1'b1);
        peer.send_async(8'h11, 1'b0, 1'b0);
        cyc(4);
        check({framing_error_flag, full, receive_full_interrupt}, 3'b000);
        peer.send_async(8'h42, 1'b1, 1'b1);
        cyc(4);
        check({full, received_marker_bit, wt, receive_full_interrupt}, 4'b1101);
        check({framing_error_flag, parity_error_flag, receive_buffer}, {2'b00, 8'h42});
        peer.send_async(8'h99, 1'b0, 1'b1);
        cyc(4);
        check({full, ovr, receive_error_interrupt, receive_buffer}, {3'b111, 8'h42});
        re = 1'b0;
        cyc(2);
        check({full, ovr, receive_buffer}, {2'b11, 8'h42});
        $display("multiprocessor test done");
    endtask : test_mp

    task automatic test_sync_ext;
        mp = 1'b0;
        sync = 1'b1;
        selh = 1'b1;
        transmit_empty_irq_enable = 1'b1;
        transmit_end_irq_enable = 1'b1;
        cyc(1);
        te = 1'b1;
        re = 1'b1;
        put_word(8'hC3);
        cyc(20);
        check(empty, 1'b0);
        clear_all;
        cyc(3);
        check({empty, transmit_empty_interrupt}, 2'b11);
        put_word(8'h16);
        cyc(3);
        peer.sync_frame(8'h5A, got);
        cyc(5);
        check(got, 8'hC3);
        check({full, receive_buffer}, {1'b1, 8'h5A});
        pulse(cf);
        peer.sync_frame(8'h81, got);
        cyc(5);
        check(got, 8'h16);
        check({transmit_end_flag, transmit_end_interrupt, txd, receive_buffer}, {3'b110, 8'h81});
        check(sck_oe, 1'b0);
        $display("external clock test done");
    endtask : test_sync_ext

    task automatic test_sync_int;
        te = 1'b0;
        re = 1'b0;
        cyc(2);
        selh = 1'b0;
        cyc(1);
        te = 1'b1;
        falls = 0;
        put_word(8'h3C);
        cyc(3);
        wait_end;
        cyc(2);
        check(falls[15:0], 16'd8);
        check({sck_o, txd, transmit_end_interrupt}, 3'b101);
        check(sck_oe, 1'b1);
        // a second word waiting behind a running frame is dropped when the transmitter is shut
        put_word(8'hF0);
        put_word(8'h0F);
        cyc(4);
        te = 1'b0;
        cyc(2);
        check(empty, 1'b1);
        $display("internal clock test done");
    endtask : test_sync_int

    task automatic test_async_tx;
        logic [10:0] fr;
        te = 1'b0;
        re = 1'b0;
        cyc(2);
        sync = 1'b0;
        mp = 1'b1;
        par = 1'b1;
        mkt = 1'b1;
        cyc(1);
        te = 1'b1;
        put_word(8'hA5);
        peer.get_async(fr);
        check(fr, {1'b1, 1'b1, 8'hA5, 1'b0});
        mkt = 1'b0;
        put_word(8'h5A);
        peer.get_async(fr);
        check(fr, {1'b1, 1'b0, 8'h5A, 1'b0});
        $display("async transmit test done");
    endtask : test_async_tx

    task automatic test_sync_msb;
        te = 1'b0;
        re = 1'b0;
        cyc(2);
        mp = 1'b0;
        par = 1'b0;
        sync = 1'b1;
        selh = 1'b1;
        msbf = 1'b1;
        pulse(cf);
        te = 1'b1;
        re = 1'b1;
        put_word(8'hC1);
        cyc(3);
        peer.sync_frame(8'h1E, got);
        cyc(5);
        check(got, 8'h83);
        check({full, receive_buffer}, {1'b1, 8'h78});
        $display("msb first test done");
    endtask : test_sync_msb

    initial begin
        rst = 1'b1;
        {sync, mp, par, selh, te, re, transmit_empty_irq_enable, transmit_end_irq_enable, receive_irq_enable, setw, txv} = '0;
        {cf, co, cfe, cpe, mkt, msbf} = '0;
        div = 8'h01;
        txdat = 8'h00;
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        cyc(2);
        test_reset;
        test_mp;
        test_sync_ext;
        test_sync_int;
        test_async_tx;
        test_sync_msb;
        give_verdict;
    end
endmodule : test_smsm_serial_unit
`default_nettype wire
